//--- shared/spm_pkg.sv
/*
  spm_pkg: constants, pin indices and carrier types for the serial pin
  sharing block. Assumes one system clock domain plus the SPI slave clock.
*/
`default_nettype none
package spm_pkg;

  // ****************************************************************
  // shared serial pin positions (pad vector index)
  // ****************************************************************
  localparam int unsigned SER_PINS   = 8;
  localparam int unsigned TMR_PINS   = 8;
  localparam int unsigned IDX_S0_TX  = 0;  // port_e_line_0
  localparam int unsigned IDX_S0_RX  = 1;  // port_e_line_1
  localparam int unsigned IDX_SCLK   = 2;  // port_e_line_4
  localparam int unsigned IDX_MOSI   = 3;  // port_e_line_5
  localparam int unsigned IDX_MISO   = 4;  // port_e_line_6
  localparam int unsigned IDX_SS     = 5;  // port_e_line_7
  localparam int unsigned IDX_S1_TX  = 6;  // port_d_line_6
  localparam int unsigned IDX_S1_RX  = 7;  // port_d_line_7

  // ****************************************************************
  // timer pin positions: decoder 0 on timer a, decoder 1 on timer b
  // ****************************************************************
  localparam int unsigned IDX_DEC0   = 0;
  localparam int unsigned IDX_DEC1   = 4;

  // ****************************************************************
  // reset values and widths
  // ****************************************************************
  localparam logic [7:0] SEL_RST     = 8'h00;  // 0 = peripheral function
  localparam logic [7:0] DIR_RST     = 8'h00;  // 0 = input
  localparam logic [7:0] OUT_RST     = 8'h00;
  localparam logic [7:0] TSEL_RST    = 8'h00;  // 0 = decoder input only
  localparam int unsigned BYTE_W     = 8;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [2:0] BIT_RST     = 3'h0;
  localparam int unsigned BUF_DEPTH  = 2;
  localparam logic [1:0] BUF_FULL    = 2'h2;
  localparam logic [1:0] CNT_RST     = 2'h0;
  localparam logic [7:0] PAD_IDLE    = 8'ha2;  // ss and serial rx idle high

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index_in;
    logic home_in;
  } spm_dec_t;

  typedef struct packed {
    logic [7:0] sel;  // 1 = general purpose pin
    logic [7:0] dir;  // 1 = output
    logic [7:0] dat;
  } spm_gpio_cfg_t;

endpackage : spm_pkg
`default_nettype wire

//--- design/spm_serial_pin_sharing.sv
/*
  spm_serial_pin_sharing: pin sharing for spi, two serial channels and two
  quadrature decoders over timer a/b pins, plus an spi slave byte capture
  on the link clock with a two-entry buffer. Assumes the spi, serial and
  timer cores sit on CLK_SYS_I and the testbench resolves pad wires.
*/
// Functional notes
// - unselected spi slave releases its miso pin
// - master presents each mosi bit half a period before the sampling edge
// - master drives sclk out; slave takes sclk in as data clock
// - ss selects the slave; in master mode low ss flags a conflict
// - after reset the four port e spi pins carry spi functions
// - pins in general purpose use get an individual direction each
// - each serial channel has tx out and rx in, default after reset
// - each decoder takes phase a, phase b, index, home from timer pins
`timescale 1ns/1ps
`default_nettype none
module spm_serial_pin_sharing (
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RST_I,
  input  wire logic                  CE_I,
  input  wire logic                  LINK_SCLK_I,
  input  wire logic [7:0]            PAD_I,
  output logic      [7:0]            PAD_O,
  output logic      [7:0]            PAD_OE_O,
  input  wire logic [7:0]            TMR_PAD_I,
  output logic      [7:0]            TMR_PAD_O,
  output logic      [7:0]            TMR_PAD_OE_O,
  input  wire logic                  CFG_WE_I,
  input  wire spm_pkg::spm_gpio_cfg_t CFG_I,
  output logic      [7:0]            GPIO_IN_O,
  input  wire logic                  SPI_MASTER_I,
  input  wire logic                  SPI_SCLK_I,
  input  wire logic                  SPI_MOSI_I,
  input  wire logic                  SPI_MISO_I,
  output logic                       SPI_MISO_O,
  output logic                       SPI_SS_O,
  output logic                       SPI_MODF_O,
  input  wire logic                  SERIAL0_TX_I,
  output logic                       SERIAL0_RX_O,
  input  wire logic                  SERIAL1_TX_I,
  output logic                       SERIAL1_RX_O,
  input  wire logic                  TMR_SEL_WE_I,
  input  wire logic [7:0]            TMR_SEL_I,
  input  wire logic [7:0]            TMR_OUT_I,
  input  wire logic [7:0]            TMR_OE_I,
  output logic      [7:0]            TMR_IN_O,
  output var spm_pkg::spm_dec_t      DEC0_O,
  output var spm_pkg::spm_dec_t      DEC1_O,
  output logic                       RX_VALID_O,
  input  wire logic                  RX_READY_I,
  output logic      [7:0]            RX_DATA_O,
  output logic                       RX_DROP_O
);

  // ****************************************************************
  // link domain: spi slave byte capture
  // ****************************************************************
  logic        lnk_arst;
  logic [7:0]  shift_q, shift_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  hold_q, hold_d;
  logic        tog_q, tog_d;

  // ss high ends the frame; the link clock may stop right after
  assign lnk_arst = RST_I | PAD_I[spm_pkg::IDX_SS];

  always_comb begin
    shift_d = {shift_q[6:0], PAD_I[spm_pkg::IDX_MOSI]};
    bit_d   = bit_q + 3'h1;
    hold_d  = hold_q;
    tog_d   = tog_q;
    if (bit_q == spm_pkg::BIT_LAST) begin
      hold_d = shift_d;
      tog_d  = ~tog_q;
    end
  end

  always_ff @(posedge LINK_SCLK_I or posedge lnk_arst) begin
    if (lnk_arst) begin
      shift_q <= spm_pkg::OUT_RST;
      bit_q   <= spm_pkg::BIT_RST;
    end else begin
      shift_q <= shift_d;
      bit_q   <= bit_d;
    end
  end

  // held byte and toggle survive ss so the system side can fetch them
  always_ff @(posedge LINK_SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_q <= spm_pkg::OUT_RST;
      tog_q  <= 1'b0;
    end else begin
      hold_q <= hold_d;
      tog_q  <= tog_d;
    end
  end

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [7:0] s1_q, s2_q, t1_q, t2_q;
  logic [2:0] ts_q;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      // idle levels: no false select or start bit after reset
      s1_q <= spm_pkg::PAD_IDLE;
      s2_q <= spm_pkg::PAD_IDLE;
      t1_q <= spm_pkg::OUT_RST;
      t2_q <= spm_pkg::OUT_RST;
      ts_q <= 3'h0;
    end else if (CE_I) begin
      s1_q <= PAD_I;
      s2_q <= s1_q;
      t1_q <= TMR_PAD_I;
      t2_q <= t1_q;
      ts_q <= {ts_q[1:0], tog_q};
    end
  end

  // ****************************************************************
  // configuration and pad drive
  // ****************************************************************
  logic [7:0] sel_q, sel_d, dir_q, dir_d, dat_q, dat_d, tsel_q, tsel_d;
  logic [7:0] po_q, po_d, poe_q, poe_d, to_q, to_d, toe_q, toe_d;
  logic       master_q, master_d, modf_q, modf_d;
  logic       ss_s;

  assign ss_s = s2_q[spm_pkg::IDX_SS];

  always_comb begin
    sel_d    = sel_q;
    dir_d    = dir_q;
    dat_d    = dat_q;
    tsel_d   = tsel_q;
    master_d = SPI_MASTER_I;
    if (CFG_WE_I) begin
      sel_d = CFG_I.sel;
      dir_d = CFG_I.dir;
      dat_d = CFG_I.dat;
    end
    if (TMR_SEL_WE_I) begin
      tsel_d = TMR_SEL_I;
    end
    po_d  = spm_pkg::OUT_RST;
    poe_d = spm_pkg::DIR_RST;
    po_d[spm_pkg::IDX_S0_TX]  = SERIAL0_TX_I;
    poe_d[spm_pkg::IDX_S0_TX] = 1'b1;
    po_d[spm_pkg::IDX_S1_TX]  = SERIAL1_TX_I;
    poe_d[spm_pkg::IDX_S1_TX] = 1'b1;
    po_d[spm_pkg::IDX_SCLK]   = SPI_SCLK_I;
    poe_d[spm_pkg::IDX_SCLK]  = master_q;
    po_d[spm_pkg::IDX_MOSI]   = SPI_MOSI_I;
    poe_d[spm_pkg::IDX_MOSI]  = master_q;
    po_d[spm_pkg::IDX_MISO]   = SPI_MISO_I;
    poe_d[spm_pkg::IDX_MISO]  = ~master_q & ~ss_s;
    for (int i = 0; i < spm_pkg::SER_PINS; i++) begin
      if (sel_q[i]) begin
        po_d[i]  = dat_q[i];
        poe_d[i] = dir_q[i];
      end
    end
    to_d  = TMR_OUT_I;
    toe_d = TMR_OE_I & tsel_q;
    modf_d = master_q & ~ss_s;
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sel_q    <= spm_pkg::SEL_RST;
      dir_q    <= spm_pkg::DIR_RST;
      dat_q    <= spm_pkg::OUT_RST;
      tsel_q   <= spm_pkg::TSEL_RST;
      po_q     <= spm_pkg::OUT_RST;
      poe_q    <= spm_pkg::DIR_RST;
      to_q     <= spm_pkg::OUT_RST;
      toe_q    <= spm_pkg::DIR_RST;
      master_q <= 1'b0;
      modf_q   <= 1'b0;
    end else if (CE_I) begin
      sel_q    <= sel_d;
      dir_q    <= dir_d;
      dat_q    <= dat_d;
      tsel_q   <= tsel_d;
      po_q     <= po_d;
      poe_q    <= poe_d;
      to_q     <= to_d;
      toe_q    <= toe_d;
      master_q <= master_d;
      modf_q   <= modf_d;
    end
  end

  assign PAD_O        = po_q;
  assign PAD_OE_O     = poe_q;
  assign TMR_PAD_O    = to_q;
  assign TMR_PAD_OE_O = toe_q;
  assign GPIO_IN_O    = s2_q;
  assign SPI_MISO_O   = s2_q[spm_pkg::IDX_MISO];
  assign SPI_SS_O     = ss_s;
  assign SPI_MODF_O   = modf_q;
  assign SERIAL0_RX_O = s2_q[spm_pkg::IDX_S0_RX];
  assign SERIAL1_RX_O = s2_q[spm_pkg::IDX_S1_RX];
  assign TMR_IN_O     = t2_q;

  // channel 0 of each timer carries phase a, which is the struct msb
  function automatic spm_pkg::spm_dec_t dec_pick(input logic [3:0] v);
    dec_pick = '{phase_a: v[0], phase_b: v[1], index_in: v[2], home_in: v[3]};
  endfunction : dec_pick

  assign DEC0_O = dec_pick(t2_q[spm_pkg::IDX_DEC0 +: $bits(spm_pkg::spm_dec_t)]);
  assign DEC1_O = dec_pick(t2_q[spm_pkg::IDX_DEC1 +: $bits(spm_pkg::spm_dec_t)]);

  // ****************************************************************
  // two-entry receive buffer
  // ****************************************************************
  logic [7:0] mem_q [spm_pkg::BUF_DEPTH];
  logic [7:0] mem_d [spm_pkg::BUF_DEPTH];
  logic       wp_q, wp_d, rp_q, rp_d, drop_q, drop_d;
  logic [1:0] cnt_q, cnt_d;
  logic       ev, push, pop, full;

  // held byte is stable for many link edges after the toggle moves
  assign ev   = ts_q[2] ^ ts_q[1];
  assign full = (cnt_q == spm_pkg::BUF_FULL);
  assign push = ev & ~master_q & ~sel_q[spm_pkg::IDX_MOSI] & ~full;
  assign pop  = RX_VALID_O & RX_READY_I;

  always_comb begin
    mem_d  = mem_q;
    wp_d   = wp_q;
    rp_d   = rp_q;
    cnt_d  = cnt_q;
    drop_d = ev & ~master_q & ~sel_q[spm_pkg::IDX_MOSI] & full;
    if (push) begin
      mem_d[wp_q] = hold_q;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    // spi cannot be stalled, so a byte meeting a full buffer is dropped
    case ({push, pop})
      2'b10:   cnt_d = cnt_q + 2'h1;
      2'b01:   cnt_d = cnt_q - 2'h1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mem_q[0] <= spm_pkg::OUT_RST;
      mem_q[1] <= spm_pkg::OUT_RST;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= spm_pkg::CNT_RST;
      drop_q   <= 1'b0;
    end else if (CE_I) begin
      mem_q  <= mem_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      drop_q <= drop_d;
    end
  end

  assign RX_VALID_O = (cnt_q != spm_pkg::CNT_RST);
  assign RX_DATA_O  = mem_q[rp_q];
  assign RX_DROP_O  = drop_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  miso_release_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (CE_I && !master_q && ss_s && !sel_q[spm_pkg::IDX_MISO])
      |=> !PAD_OE_O[spm_pkg::IDX_MISO]) else $error("miso driven while unselected");
  mosi_sample_a: assert property (@(posedge LINK_SCLK_I) disable iff (RST_I)
    (bit_q == spm_pkg::BIT_LAST) |=> (hold_q == $past(shift_d)))
    else $error("captured byte differs from sampled bits");
  sclk_master_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (CE_I && master_q && !sel_q[spm_pkg::IDX_SCLK]) |=>
      (PAD_OE_O[spm_pkg::IDX_SCLK] && PAD_O[spm_pkg::IDX_SCLK] == $past(SPI_SCLK_I)))
    else $error("sclk not driven in master mode");
  conflict_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (CE_I && master_q && !ss_s) |=> SPI_MODF_O) else $error("ss conflict missed");
  spi_default_a: assert property (@(posedge CLK_SYS_I)
    ($past(RST_I) && !RST_I) |-> (sel_q == spm_pkg::SEL_RST))
    else $error("pins not on spi after reset");
  gpio_dir_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I |=> ((PAD_OE_O & $past(sel_q)) == ($past(dir_q) & $past(sel_q))))
    else $error("gpio direction not applied");
  serial_tx_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (CE_I && !sel_q[spm_pkg::IDX_S0_TX]) |=>
      (PAD_OE_O[spm_pkg::IDX_S0_TX] && PAD_O[spm_pkg::IDX_S0_TX] == $past(SERIAL0_TX_I)))
    else $error("serial tx not driven");
  dec_route_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (CE_I && $past(CE_I) && !$past(RST_I)) |=>
      (DEC1_O == dec_pick($past(TMR_PAD_I[spm_pkg::IDX_DEC1 +: 4], 2))))
    else $error("decoder inputs misrouted");
  reset_release_a: assert property (@(posedge CLK_SYS_I)
    RST_I |-> (PAD_OE_O == 8'h00 && TMR_PAD_OE_O == 8'h00))
    else $error("pin driven during reset");
  buf_bound_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    cnt_q <= spm_pkg::BUF_FULL) else $error("buffer overflow");

  byte_rx_c:  cover property (@(posedge CLK_SYS_I) disable iff (RST_I) push);
  drop_c:     cover property (@(posedge CLK_SYS_I) disable iff (RST_I) RX_DROP_O);
  full_c:     cover property (@(posedge CLK_SYS_I) disable iff (RST_I) full ##1 pop);
  conflict_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) SPI_MODF_O);

endmodule : spm_serial_pin_sharing
`default_nettype wire

//--- dv/spm_peer.sv
/*
  spm_peer: external spi master on the slave pins of the pin sharing block.
  assumes the bench calls send_byte and resolves the pad wires.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_peer (
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o
);
  // ****************************************************************
  // frame driver
  // ****************************************************************
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end
  task automatic send_byte(input logic [7:0] b);
    ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    ss_n_o = 1'b1;
    // released line must not show a stale level
    mosi_o = ~b[0];
    #125;
  endtask : send_byte
endmodule : spm_peer
`default_nettype wire

//--- dv/spm_serial_pin_sharing_bench.sv
/*
  spm_serial_pin_sharing_bench: self-checking bench of the pin sharing block.
  assumes spm_pkg, the design and spm_peer are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_serial_pin_sharing_bench;
  logic                   clk = 1'b0, rst = 1'b0, ce = 1'b1;
  logic                   master = 1'b0, cfg_we = 1'b0, tsel_we = 1'b0, rdy = 1'b0;
  logic                   ss_drv = 1'b1, s_sclk = 1'b0, s_mosi = 1'b0, s_miso = 1'b1;
  logic                   tx0 = 1'b1, tx1 = 1'b0, drop_seen = 1'b0;
  logic [7:0]             pad_drv = 8'h82, tmr_ext = 8'h00, tsel = 8'h00;
  logic [7:0]             tmr_out = 8'h00, tmr_oe = 8'h00;
  spm_pkg::spm_gpio_cfg_t cfg = '0;
  logic [7:0]             pad_o, pad_oe, tpad_o, tpad_oe, gpio_in, tmr_in, rx_data;
  logic                   miso_o, ss_o, modf, rx0, rx1, rx_valid, rx_drop, p_sclk, p_mosi, p_ss;
  spm_pkg::spm_dec_t      dec0, dec1;
  int                     err_count = 0, n_tests = 0;
  wire [7:0] ext = {pad_drv[7:6], p_ss & ss_drv, pad_drv[4], p_mosi, p_sclk, pad_drv[1:0]};
  // pad wire: driver wins where enabled, else the outside level
  wire [7:0] pad_i = (pad_oe & pad_o) | (~pad_oe & ext);
  wire [7:0] tpad_i = (tpad_oe & tpad_o) | (~tpad_oe & tmr_ext);

  always #2.5 clk = ~clk;
  always @(posedge clk) if (rx_drop === 1'b1) drop_seen <= 1'b1;

  spm_peer peer_u (.sclk_o(p_sclk), .mosi_o(p_mosi), .ss_n_o(p_ss));
  spm_serial_pin_sharing dut_u (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .LINK_SCLK_I(p_sclk), .PAD_I(pad_i),
    .PAD_O(pad_o), .PAD_OE_O(pad_oe), .TMR_PAD_I(tpad_i), .TMR_PAD_O(tpad_o),
    .TMR_PAD_OE_O(tpad_oe), .CFG_WE_I(cfg_we), .CFG_I(cfg), .GPIO_IN_O(gpio_in),
    .SPI_MASTER_I(master), .SPI_SCLK_I(s_sclk), .SPI_MOSI_I(s_mosi), .SPI_MISO_I(s_miso),
    .SPI_MISO_O(miso_o), .SPI_SS_O(ss_o), .SPI_MODF_O(modf), .SERIAL0_TX_I(tx0),
    .SERIAL0_RX_O(rx0), .SERIAL1_TX_I(tx1), .SERIAL1_RX_O(rx1), .TMR_SEL_WE_I(tsel_we),
    .TMR_SEL_I(tsel), .TMR_OUT_I(tmr_out), .TMR_OE_I(tmr_oe), .TMR_IN_O(tmr_in),
    .DEC0_O(dec0), .DEC1_O(dec1), .RX_VALID_O(rx_valid), .RX_READY_I(rdy),
    .RX_DATA_O(rx_data), .RX_DROP_O(rx_drop));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic set_cfg(input logic [7:0] sel, input logic [7:0] dir, input logic [7:0] dat);
    @(posedge clk);
    cfg <= '{sel: sel, dir: dir, dat: dat};
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    cyc(4);
  endtask : set_cfg
  task automatic pop();
    @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
    #1;
  endtask : pop
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    cyc(6);
    chk("pad oe in reset", 8'h00, pad_oe);
    chk("timer oe in reset", 8'h00, tpad_oe);
    @(posedge clk);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    chk("pad oe after reset", 8'h41, pad_oe);
    chk1("tx0 pin", tx0, pad_o[0]);
    chk1("tx1 pin", tx1, pad_o[6]);
    chk1("rx0", ext[1], rx0);
    chk1("rx1", ext[7], rx1);
    chk1("ss level", 1'b1, ss_o);
    $display("test reset done");
  endtask : t_reset
  task automatic t_master();
    @(posedge clk);
    master <= 1'b1;
    s_sclk <= 1'b1;
    s_mosi <= 1'b1;
    cyc(4);
    chk("master oe", 8'h4d, pad_oe);
    chk1("sclk out", 1'b1, pad_o[2]);
    chk1("mosi out", 1'b1, pad_o[3]);
    @(posedge clk);
    pad_drv[4] <= 1'b1;
    ss_drv <= 1'b0;
    cyc(4);
    chk1("miso in", 1'b1, miso_o);
    chk1("conflict", 1'b1, modf);
    @(posedge clk);
    master <= 1'b0;
    ss_drv <= 1'b1;
    cyc(4);
    chk1("conflict gone", 1'b0, modf);
    chk1("sclk released", 1'b0, pad_oe[2]);
    $display("test master done");
  endtask : t_master
  task automatic t_slave();
    @(posedge clk);
    ss_drv <= 1'b0;
    s_miso <= 1'b0;
    cyc(4);
    chk1("miso oe sel", 1'b1, pad_oe[4]);
    chk1("miso out", 1'b0, pad_o[4]);
    @(posedge clk);
    ss_drv <= 1'b1;
    cyc(4);
    chk1("miso oe unsel", 1'b0, pad_oe[4]);
    peer_u.send_byte(8'ha5);
    peer_u.send_byte(8'h3c);
    peer_u.send_byte(8'h81);
    cyc(10);
    chk1("rx valid", 1'b1, rx_valid);
    chk1("overrun drop", 1'b1, drop_seen);
    chk("rx first", 8'ha5, rx_data);
    pop();
    chk("rx second", 8'h3c, rx_data);
    pop();
    chk1("rx empty", 1'b0, rx_valid);
    $display("test slave done");
  endtask : t_slave
  task automatic t_gpio();
    set_cfg(8'hff, 8'h5a, 8'h3c);
    chk("gpio oe a", 8'h5a, pad_oe);
    chk("gpio out a", 8'h18, pad_o & 8'h5a);
    chk("gpio in a", ext & 8'ha5, gpio_in & 8'ha5);
    set_cfg(8'hff, 8'ha5, 8'hff);
    chk("gpio oe b", 8'ha5, pad_oe);
    set_cfg(8'h00, 8'h00, 8'h00);
    chk("spi pins back", 8'h41, pad_oe);
    $display("test gpio done");
  endtask : t_gpio
  task automatic t_timer();
    @(posedge clk);
    tmr_ext <= 8'hc5;
    cyc(4);
    chk("decoders", 8'ha3, {dec0, dec1});
    chk("timer in", 8'hc5, tmr_in);
    @(posedge clk);
    tsel <= 8'h0f;
    tsel_we <= 1'b1;
    tmr_oe <= 8'h33;
    tmr_out <= 8'hff;
    @(posedge clk);
    tsel_we <= 1'b0;
    cyc(4);
    chk("timer oe", 8'h03, tpad_oe);
    chk("timer out", 8'h03, tpad_o & 8'h03);
    $display("test timer done");
  endtask : t_timer
  task automatic t_hold();
    @(posedge clk);
    ce <= 1'b0;
    tx0 <= 1'b0;
    cyc(4);
    chk1("tx0 frozen", 1'b1, pad_o[0]);
    @(posedge clk);
    ce <= 1'b1;
    cyc(4);
    chk1("tx0 resumes", 1'b0, pad_o[0]);
    $display("test hold done");
  endtask : t_hold

  // ****************************************************************
  // sequence and watchdog
  // ****************************************************************
  initial begin
    rst <= 1'b1;
    t_reset();
    t_master();
    t_slave();
    t_gpio();
    t_timer();
    t_hold();
    finish_test();
  end
  // whole run needs about 4 us; allow 25 times that
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule : spm_serial_pin_sharing_bench
`default_nettype wire
